//--- hdl/hpc_slot_ctrl.sv
// Downstream slot hot-plug controller with APB register access
`timescale 1ns/10ps
module hpc_slot_ctrl #(
  parameter int ILOCK_CYCLES = hpc_pkg::ILOCK_CYC
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Configuration load path, same clock
  input  wire logic        cfg_load_en,
  input  wire logic [7:0]  cfg_load_addr,
  input  wire logic [31:0] cfg_load_data,
  // Power state context
  input  wire logic        switch_d3hot,
  input  wire logic        d3cold,
  // Slot inputs from the expander, asynchronous
  input  wire logic        button_in,
  input  wire logic        presence_in,
  input  wire logic        power_fault_in,
  input  wire logic        latch_sensor_in,
  input  wire logic        power_good_in,
  // Slot outputs toward the expander
  output logic             attention_led_out,
  output logic             power_led_out,
  output logic             slot_power_enable_out,
  output logic             interlock_out,
  // General-purpose pin alternate function
  output logic             slot_reset_out,
  // Notification
  output logic             msi_req,
  output logic             intx_out,
  output logic             pme_msg_req
);
  logic [hpc_pkg::CAP_W-1:0] cap_r;
  logic [hpc_pkg::CTL_W-1:0] ctl_r;
  logic [hpc_pkg::CFG_W-1:0] cfg_r;
  logic [hpc_pkg::EV_N-1:0]  flag_r;
  logic [1:0]                pmstate_r;
  logic                      wake_r;
  logic [15:0]               wtmr_r;
  logic [1:0]                irqcfg_r;
  logic [hpc_pkg::IN_N-1:0]  sync1_r;
  logic [hpc_pkg::IN_N-1:0]  sync2_r;
  logic [hpc_pkg::IN_N-1:0]  prev_r;
  logic [hpc_pkg::IN_N-1:0]  lvl;
  logic                      hp_on;
  logic                      expander_on;
  logic                      apb_wr;
  logic                      apb_setup;
  logic                      ctl_wr;
  logic                      eic_wr;
  logic [hpc_pkg::EV_N-1:0]  ev_set;
  logic [hpc_pkg::EV_N-1:0]  ev_clr;
  logic [hpc_pkg::EV_N-1:0]  pend;
  logic                      irq_pend;
  logic                      irq_pend_d_r;
  logic                      in_d3hot;
  logic                      wake_ev;
  logic [31:0]               ilock_cnt_r;
  logic                      ilock_r;
  logic [6:0]                tick_cnt_r;
  logic [15:0]               wcnt_r;
  logic                      wtimer_run_r;
  logic                      pme_r;
  logic                      msi_r;
  logic                      latch_open;
  logic                      pwr_on;
  logic [31:0]               rd_val;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a[7:2] == ofs[7:2];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return hit(a, hpc_pkg::OFS_CAP) || hit(a, hpc_pkg::OFS_CTL) ||
           hit(a, hpc_pkg::OFS_STS) || hit(a, hpc_pkg::OFS_CFG) ||
           hit(a, hpc_pkg::OFS_PM)  || hit(a, hpc_pkg::OFS_WTMR) ||
           hit(a, hpc_pkg::OFS_IRQ);
  endfunction

  // Two-stage synchronisers for slot inputs
  genvar gi;
  generate
    for (gi = 0; gi < hpc_pkg::IN_N; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= (gi == hpc_pkg::IN_BTN) ? button_in :
                         (gi == hpc_pkg::IN_PRS) ? presence_in :
                         (gi == hpc_pkg::IN_PF)  ? power_fault_in :
                         (gi == hpc_pkg::IN_LAT) ? latch_sensor_in : power_good_in;
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  // Inputs are active low at the pins unless inverted
  assign lvl = ~sync2_r ^ cfg_r[hpc_pkg::IN_N-1:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= lvl;
    end
  end

  assign hp_on       = cap_r[hpc_pkg::CAP_HPC];
  assign expander_on = hp_on && cap_r[hpc_pkg::CAP_EXPE];

  // APB decode, zero wait states
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite;
  assign pready    = 1'b1;
  assign ctl_wr    = apb_wr && hit(paddr, hpc_pkg::OFS_CTL);
  assign eic_wr    = ctl_wr && pwdata[hpc_pkg::CTL_EIC] && hp_on;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= apb_setup && !mapped(paddr);
    end
  end

  // Configuration registers; the load path never reports completion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_r    <= hpc_pkg::CAP_RST;
      ctl_r    <= hpc_pkg::CTL_RST_V;
      cfg_r    <= hpc_pkg::CFG_RST;
      wtmr_r   <= hpc_pkg::WTMR_RST;
      irqcfg_r <= 2'h0;
    end else if (cfg_load_en) begin
      if (hit(cfg_load_addr, hpc_pkg::OFS_CAP)) cap_r <= cfg_load_data[hpc_pkg::CAP_W-1:0];
      if (hit(cfg_load_addr, hpc_pkg::OFS_CTL)) ctl_r <= cfg_load_data[hpc_pkg::CTL_W-1:0];
      if (hit(cfg_load_addr, hpc_pkg::OFS_CFG)) cfg_r <= cfg_load_data[hpc_pkg::CFG_W-1:0];
      if (hit(cfg_load_addr, hpc_pkg::OFS_WTMR)) wtmr_r <= cfg_load_data[15:0];
    end else if (apb_wr) begin
      if (hit(paddr, hpc_pkg::OFS_CAP)) cap_r <= pwdata[hpc_pkg::CAP_W-1:0];
      if (ctl_wr) ctl_r <= pwdata[hpc_pkg::CTL_W-1:0];
      if (hit(paddr, hpc_pkg::OFS_CFG)) cfg_r <= pwdata[hpc_pkg::CFG_W-1:0];
      if (hit(paddr, hpc_pkg::OFS_WTMR)) wtmr_r <= pwdata[15:0];
      if (hit(paddr, hpc_pkg::OFS_IRQ)) irqcfg_r <= pwdata[1:0];
    end
  end

  // Event detection
  always_comb begin
    ev_set              = '0;
    ev_set[hpc_pkg::EV_BTN] = lvl[hpc_pkg::IN_BTN] && !prev_r[hpc_pkg::IN_BTN];
    // Fault level is not held here, so outside logic must keep it up
    ev_set[hpc_pkg::EV_PF]  = lvl[hpc_pkg::IN_PF];
    ev_set[hpc_pkg::EV_LAT] = lvl[hpc_pkg::IN_LAT] != prev_r[hpc_pkg::IN_LAT];
    ev_set[hpc_pkg::EV_PRS] = lvl[hpc_pkg::IN_PRS] != prev_r[hpc_pkg::IN_PRS];
    ev_set[hpc_pkg::EV_CC]  = ctl_wr && !cfg_load_en;
    ev_set = hp_on ? ev_set : '0;
    ev_clr = (apb_wr && hit(paddr, hpc_pkg::OFS_STS)) ? pwdata[hpc_pkg::EV_N-1:0] : '0;
  end

  // Sticky flags, a new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_r <= '0;
    end else begin
      flag_r <= (flag_r & ~ev_clr) | ev_set;
    end
  end

  // Interrupt routing
  assign pend     = flag_r & ~ctl_r[hpc_pkg::EV_N-1:0];
  assign irq_pend = |pend && ctl_r[hpc_pkg::CTL_HOTPLUG_IRQ_ENABLE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_pend_d_r <= 1'b0;
      msi_r        <= 1'b0;
      intx_out     <= 1'b0;
    end else begin
      irq_pend_d_r <= irq_pend;
      msi_r        <= irq_pend && !irq_pend_d_r && irqcfg_r[hpc_pkg::IRQ_MSI];
      intx_out     <= irq_pend && !irqcfg_r[hpc_pkg::IRQ_MSI] &&
                      !irqcfg_r[hpc_pkg::IRQ_INTD];
    end
  end
  assign msi_req = msi_r;

  // Wake decision: unmasked non-completion event while in D3hot
  assign in_d3hot = (pmstate_r == hpc_pkg::PM_D3HOT) || switch_d3hot;
  assign wake_ev  = in_d3hot && !d3cold &&
                    |(ev_set[hpc_pkg::EV_CC-1:0] & ~ctl_r[hpc_pkg::EV_CC-1:0]);

  // Power state and wake status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pmstate_r <= hpc_pkg::PM_D0;
      wake_r    <= 1'b0;
    end else begin
      if (apb_wr && hit(paddr, hpc_pkg::OFS_PM)) begin
        pmstate_r <= pwdata[1:0];
      end
      if (wake_ev) begin
        wake_r <= 1'b1;
      end else if (apb_wr && hit(paddr, hpc_pkg::OFS_PM) && pwdata[hpc_pkg::PM_WAKE]) begin
        wake_r <= 1'b0;
      end
    end
  end

  // Retry timer in microsecond ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r   <= 7'h00;
      wcnt_r       <= 16'h0000;
      wtimer_run_r <= 1'b0;
      pme_r        <= 1'b0;
    end else begin
      pme_r <= 1'b0;
      if (d3cold) begin
        wtimer_run_r <= 1'b0;
      end else if (wake_ev && !wtimer_run_r) begin
        pme_r        <= 1'b1;
        wtimer_run_r <= 1'b1;
        wcnt_r       <= 16'h0000;
        tick_cnt_r   <= 7'h00;
      end else if (wtimer_run_r) begin
        if (!wake_r) begin
          wtimer_run_r <= 1'b0;
        end else if (tick_cnt_r == 7'(hpc_pkg::WTICK_CYC - 1)) begin
          tick_cnt_r <= 7'h00;
          if (wcnt_r + 16'h0001 >= wtmr_r) begin
            pme_r  <= 1'b1;
            wcnt_r <= 16'h0000;
          end else begin
            wcnt_r <= wcnt_r + 16'h0001;
          end
        end else begin
          tick_cnt_r <= tick_cnt_r + 7'h01;
        end
      end
    end
  end
  assign pme_msg_req = pme_r;

  // Interlock drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ilock_r     <= 1'b0;
      ilock_cnt_r <= 32'h0000_0000;
    end else if (eic_wr && cfg_r[hpc_pkg::CFG_TOGL]) begin
      ilock_r     <= !ilock_r;
      ilock_cnt_r <= 32'h0000_0000;
    end else if (eic_wr && !ilock_r) begin
      ilock_r     <= 1'b1;
      ilock_cnt_r <= 32'(ILOCK_CYCLES - 1);
    end else if (!cfg_r[hpc_pkg::CFG_TOGL] && ilock_r) begin
      // A write during a running pulse does not stretch it
      if (ilock_cnt_r == 32'h0000_0000) begin
        ilock_r <= 1'b0;
      end else begin
        ilock_cnt_r <= ilock_cnt_r - 32'h0000_0001;
      end
    end
  end

  // Slot power
  assign latch_open = lvl[hpc_pkg::IN_LAT] && !cfg_r[hpc_pkg::CFG_LASI];
  assign pwr_on     = ctl_r[hpc_pkg::CTL_PWR] &&
                      !(cfg_r[hpc_pkg::CFG_LAPO] && cap_r[hpc_pkg::CAP_LATP] && latch_open);

  // Slot outputs, held negated when the controller or expander is off; slot reset held negated only when the controller is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      attention_led_out     <= 1'b0;
      power_led_out         <= 1'b0;
      slot_power_enable_out <= 1'b0;
      interlock_out         <= 1'b0;
      slot_reset_out        <= 1'b0;
    end else begin
      attention_led_out     <= (expander_on && ctl_r[hpc_pkg::CTL_ATTN])
                               ^ cfg_r[hpc_pkg::CFG_IATTN];
      power_led_out         <= (expander_on && ctl_r[hpc_pkg::CTL_PLED])
                               ^ cfg_r[hpc_pkg::CFG_IPLED];
      slot_power_enable_out <= (expander_on && pwr_on) ^ cfg_r[hpc_pkg::CFG_IPWR];
      interlock_out         <= (expander_on && ilock_r) ^ cfg_r[hpc_pkg::CFG_ILOCK];
      // Reset leaves on the pin path, not through the expander
      slot_reset_out        <= (hp_on && ctl_r[hpc_pkg::CTL_RST])
                               ^ cfg_r[hpc_pkg::CFG_IRST];
    end
  end

  // Read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit(paddr, hpc_pkg::OFS_CAP)) begin
      rd_val[hpc_pkg::CAP_W-1:0] = cap_r;
    end else if (hit(paddr, hpc_pkg::OFS_CTL)) begin
      rd_val[hpc_pkg::CTL_W-1:0] = ctl_r & ~(11'h001 << hpc_pkg::CTL_EIC);
    end else if (hit(paddr, hpc_pkg::OFS_STS)) begin
      rd_val[hpc_pkg::EV_N-1:0] = flag_r;
      rd_val[hpc_pkg::STS_LATS] = lvl[hpc_pkg::IN_LAT] && !cfg_r[hpc_pkg::CFG_LASI];
      rd_val[hpc_pkg::STS_PRSS] = lvl[hpc_pkg::IN_PRS];
      rd_val[hpc_pkg::STS_EIS]  = lvl[hpc_pkg::IN_LAT] && cfg_r[hpc_pkg::CFG_LASI];
      rd_val[hpc_pkg::STS_PGD]  = lvl[hpc_pkg::IN_PGD];
    end else if (hit(paddr, hpc_pkg::OFS_CFG)) begin
      rd_val[hpc_pkg::CFG_W-1:0] = cfg_r;
    end else if (hit(paddr, hpc_pkg::OFS_PM)) begin
      rd_val[1:0]              = pmstate_r;
      rd_val[hpc_pkg::PM_WAKE] = wake_r;
    end else if (hit(paddr, hpc_pkg::OFS_WTMR)) begin
      rd_val[15:0] = wtmr_r;
    end else if (hit(paddr, hpc_pkg::OFS_IRQ)) begin
      rd_val[1:0] = irqcfg_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup && !pwrite) begin
      prdata <= rd_val;
    end
  end
endmodule

//--- common/hpc_pkg.sv
// Register map, field positions and timing constants of the slot hot-plug controller
package hpc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CAP  = 8'h00;
  localparam logic [7:0] OFS_CTL  = 8'h04;
  localparam logic [7:0] OFS_STS  = 8'h08;
  localparam logic [7:0] OFS_CFG  = 8'h0c;
  localparam logic [7:0] OFS_PM   = 8'h10;
  localparam logic [7:0] OFS_WTMR = 8'h14;
  localparam logic [7:0] OFS_IRQ  = 8'h18;
  // slot_capability_reg
  localparam int CAP_HPC  = 0;
  localparam int CAP_LATP = 1;
  localparam int CAP_EXPE = 2;
  localparam int CAP_W    = 3;
  // slot_control_reg: bits 4:0 are event masks in slot_status_reg order
  localparam int CTL_HOTPLUG_IRQ_ENABLE = 5;
  localparam int CTL_PWR  = 6;
  localparam int CTL_ATTN = 7;
  localparam int CTL_PLED = 8;
  localparam int CTL_EIC  = 9;
  localparam int CTL_RST  = 10;
  localparam int CTL_W    = 11;
  // slot_status_reg events and states
  localparam int EV_BTN   = 0;
  localparam int EV_PF    = 1;
  localparam int EV_LAT   = 2;
  localparam int EV_PRS   = 3;
  localparam int EV_CC    = 4;
  localparam int EV_N     = 5;
  localparam int STS_LATS = 5;
  localparam int STS_PRSS = 6;
  localparam int STS_EIS  = 7;
  localparam int STS_PGD  = 8;
  // Input index into synchroniser array and inversion bits 4:0
  localparam int IN_BTN = 0;
  localparam int IN_PRS = 1;
  localparam int IN_PF  = 2;
  localparam int IN_LAT = 3;
  localparam int IN_PGD = 4;
  localparam int IN_N   = 5;
  // hotplug_config_reg: output inversion 9:5, modes above
  localparam int CFG_IATTN = 5;
  localparam int CFG_IPLED = 6;
  localparam int CFG_IPWR  = 7;
  localparam int CFG_ILOCK = 8;
  localparam int CFG_IRST  = 9;
  localparam int CFG_TOGL  = 10;
  localparam int CFG_LASI  = 11;
  localparam int CFG_LAPO  = 12;
  localparam int CFG_W     = 13;
  // pm_control_status_reg
  localparam logic [1:0] PM_D0    = 2'h0;
  localparam logic [1:0] PM_D3HOT = 2'h3;
  localparam int PM_WAKE = 15;
  // irq config register
  localparam int IRQ_MSI  = 0;
  localparam int IRQ_INTD = 1;
  // Reset values
  localparam logic [CAP_W-1:0] CAP_RST  = 3'h0;
  localparam logic [CTL_W-1:0] CTL_RST_V = 11'h01f;
  localparam logic [CFG_W-1:0] CFG_RST  = 13'h0000;
  localparam logic [15:0]      WTMR_RST = 16'h0064;
  // Timing
  localparam int CLK_MHZ        = 100;
  localparam int ILOCK_PULSE_MS = 125;
  localparam int ILOCK_CYC      = ILOCK_PULSE_MS * CLK_MHZ * 1000;
  localparam int WTICK_US       = 1;
  localparam int WTICK_CYC      = WTICK_US * CLK_MHZ;
endpackage

//--- dv/hpc_expander.sv
// Behavioural slot I/O expander driving the active-low slot sensor pins
`timescale 1ns/10ps
module hpc_expander (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Asserted levels wanted by the bench, in input index order
  input  wire logic [4:0] want,
  // Slot output seen at the expander
  input  wire logic       slot_power_enable_out,
  // Active-low slot pins
  output logic            button_in,
  output logic            presence_in,
  output logic            power_fault_in,
  output logic            latch_sensor_in,
  output logic            power_good_in
);
  logic pf_hold_r;
  logic pwr_q_r;

  // Fault stays asserted until power enable moves, since the switch keeps no copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_hold_r <= 1'b0;
      pwr_q_r   <= 1'b0;
    end else begin
      pwr_q_r <= slot_power_enable_out;
      if (want[hpc_pkg::IN_PF]) begin
        pf_hold_r <= 1'b1;
      end else if (pwr_q_r != slot_power_enable_out) begin
        pf_hold_r <= 1'b0;
      end
    end
  end

  assign button_in       = ~want[hpc_pkg::IN_BTN];
  assign presence_in     = ~want[hpc_pkg::IN_PRS];
  assign power_fault_in  = ~(want[hpc_pkg::IN_PF] | pf_hold_r);
  assign latch_sensor_in = ~want[hpc_pkg::IN_LAT];
  assign power_good_in   = ~want[hpc_pkg::IN_PGD];
endmodule

//--- dv/hpc_slot_ctrl_asserts.sv
// Port-level checker of the slot hot-plug controller
`timescale 1ns/10ps
module hpc_checker #(
  parameter int ILOCK_CYCLES = 50
) (
  // Clock, reset and writes
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        cfg_load_en,
  input wire logic [7:0]  cfg_load_addr,
  input wire logic [31:0] cfg_load_data,
  // Slot side and notification
  input wire logic        d3cold,
  input wire logic        latch_sensor_in,
  input wire logic        attention_led_out,
  input wire logic        power_led_out,
  input wire logic        slot_power_enable_out,
  input wire logic        interlock_out,
  input wire logic        slot_reset_out,
  input wire logic        msi_req,
  input wire logic        intx_out,
  input wire logic        pme_msg_req
);
  logic [2:0]  cap_r;
  logic [10:0] ctl_r;
  logic [12:0] cfg_r;
  int          hi_r;
  logic        wr;
  logic        on;
  logic        eic_wr;
  logic        rd_sts;
  logic [7:0]  wa;
  logic [31:0] wd;

  // Shadows follow the load-beats-bus priority
  always_comb begin
    wr     = cfg_load_en | (psel & penable & pwrite);
    wa     = cfg_load_en ? cfg_load_addr : paddr;
    wd     = cfg_load_en ? cfg_load_data : pwdata;
    on     = cap_r[hpc_pkg::CAP_HPC] & cap_r[hpc_pkg::CAP_EXPE];
    eic_wr = psel & penable & pwrite & !cfg_load_en & on
             & (paddr == hpc_pkg::OFS_CTL) & pwdata[hpc_pkg::CTL_EIC];
    rd_sts = psel & penable & !pwrite & (paddr == hpc_pkg::OFS_STS);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_r <= hpc_pkg::CAP_RST;
      ctl_r <= hpc_pkg::CTL_RST_V;
      cfg_r <= hpc_pkg::CFG_RST;
    end else if (wr) begin
      if (cfg_load_en && wa == hpc_pkg::OFS_CAP) begin
        cap_r <= wd[2:0];
      end
      if (wa == hpc_pkg::OFS_CTL) begin
        ctl_r <= wd[10:0];
      end
      if (wa == hpc_pkg::OFS_CFG) begin
        cfg_r <= wd[12:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_r <= 0;
    end else begin
      hi_r <= interlock_out ? hi_r + 1 : 0;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence pulse_req_s;
    eic_wr && !cfg_r[10] && !cfg_r[8] && !interlock_out;
  endsequence

  a_no_wake_cold : assert property (
    d3cold && $past(d3cold) |-> !pme_msg_req) else $error("wake sent while cold");
  a_irq_gated : assert property (
    (!ctl_r[5])[*3] |-> !intx_out && !msi_req) else $error("irq while disabled");
  a_idle_outputs : assert property (
    (!on && $stable(cfg_r))[*3] |-> attention_led_out == cfg_r[5]
    && power_led_out == cfg_r[6] && slot_power_enable_out == cfg_r[7]
    && interlock_out == cfg_r[8]) else $error("outputs active while off");
  a_reset_pin : assert property (
    slot_reset_out == $past((ctl_r[10] & cap_r[0]) ^ cfg_r[9])) else $error("slot reset wrong");
  a_toggle_inverts : assert property (
    eic_wr && cfg_r[10] |-> ##[1:3] $changed(interlock_out)) else $error("no toggle");
  a_pulse_starts : assert property (
    pulse_req_s |-> ##[1:3] $rose(interlock_out)) else $error("no lock pulse");
  a_pulse_length : assert property (
    $fell(interlock_out) && !cfg_r[10] && !cfg_r[8] && on |-> hi_r == ILOCK_CYCLES)
    else $error("lock pulse length wrong");
  a_latch_poweroff : assert property (
    (cap_r[1] && cfg_r[12] && !cfg_r[11] && on && $stable(cfg_r)
    && latch_sensor_in == cfg_r[3])[*6] |-> slot_power_enable_out == cfg_r[7])
    else $error("power on with latch open");
  a_lock_flag_zero : assert property (
    rd_sts && !cfg_r[11] |-> !prdata[7]) else $error("lock flag not zero");
  a_latch_closed : assert property (
    rd_sts && cfg_r[11] |-> !prdata[5]) else $error("latch not closed");
  a_wake_pulse : assert property (
    pme_msg_req |=> !pme_msg_req) else $error("wake pulse too long");
endmodule

bind hpc_slot_ctrl hpc_checker #(.ILOCK_CYCLES(ILOCK_CYCLES)) chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .cfg_load_en(cfg_load_en),
  .cfg_load_addr(cfg_load_addr), .cfg_load_data(cfg_load_data), .d3cold(d3cold),
  .latch_sensor_in(latch_sensor_in), .attention_led_out(attention_led_out),
  .power_led_out(power_led_out), .slot_power_enable_out(slot_power_enable_out),
  .interlock_out(interlock_out), .slot_reset_out(slot_reset_out), .msi_req(msi_req),
  .intx_out(intx_out), .pme_msg_req(pme_msg_req));

//--- dv/downstream_slot_hotplug_controller_test.sv
// Self-checking bench of the slot hot-plug controller
`timescale 1ns/10ps
module downstream_slot_hotplug_controller_test;
  localparam int ILK = 50;
  logic        pclk, presetn, psel, penable, pwrite, cfg_load_en, switch_d3hot, d3cold;
  logic        pready, pslverr, er, btn, prs, pf, lat, pgd;
  logic        attn, pled, pwr, ilk, srst, msi, intx, pme;
  logic [7:0]  paddr, cfg_load_addr;
  logic [31:0] pwdata, cfg_load_data, prdata, rd;
  logic [4:0]  want;
  int          fail_count, checked, pme_cnt, msi_cnt, n;
  logic [7:0]  ra[6] = '{hpc_pkg::OFS_CAP, hpc_pkg::OFS_CTL, hpc_pkg::OFS_CFG,
                         hpc_pkg::OFS_PM, hpc_pkg::OFS_WTMR, hpc_pkg::OFS_IRQ};
  logic [31:0] rv[6] = '{32'h0, 32'h1f, 32'h0, 32'h0, 32'h64, 32'h0};

  hpc_slot_ctrl #(.ILOCK_CYCLES(ILK)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .cfg_load_en(cfg_load_en),
    .cfg_load_addr(cfg_load_addr), .cfg_load_data(cfg_load_data),
    .switch_d3hot(switch_d3hot), .d3cold(d3cold), .button_in(btn), .presence_in(prs),
    .power_fault_in(pf), .latch_sensor_in(lat), .power_good_in(pgd),
    .attention_led_out(attn), .power_led_out(pled), .slot_power_enable_out(pwr),
    .interlock_out(ilk), .slot_reset_out(srst), .msi_req(msi), .intx_out(intx),
    .pme_msg_req(pme));
  hpc_expander exp_i (.pclk(pclk), .presetn(presetn), .want(want),
    .slot_power_enable_out(pwr), .button_in(btn), .presence_in(prs),
    .power_fault_in(pf), .latch_sensor_in(lat), .power_good_in(pgd));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (pme === 1'b1) pme_cnt++;
    if (msi === 1'b1) msi_cnt++;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // Sample settled access-phase values, then release after the ready edge
    do begin
      @(negedge pclk);
      k++;
      rd = prdata;
      er = pslverr;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) fail_count++;
    @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Clears wake and event state first so leftovers never count
  task automatic ev_case(input logic [31:0] ctl, input logic [31:0] pm, input logic cold,
                         input logic sw, input int src, input int wt, input int ep,
                         input int em, input logic ei);
    int p0;
    int m0;
    d3cold       <= cold;
    switch_d3hot <= sw;
    apb(1'b1, hpc_pkg::OFS_PM, pm | 32'h8000);
    apb(1'b1, hpc_pkg::OFS_STS, 32'h1f);
    p0 = pme_cnt;
    m0 = msi_cnt;
    apb(1'b1, hpc_pkg::OFS_CTL, ctl);
    if (src < 5) want[src] <= ~want[src];
    repeat (wt) @(posedge pclk);
    check("wake count", 32'(pme_cnt - p0), 32'(ep));
    check("msi count", 32'(msi_cnt - m0), 32'(em));
    check("intx", 32'(intx), 32'(ei));
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, cfg_load_en, switch_d3hot, d3cold, presetn} = '0;
    {paddr, cfg_load_addr, pwdata, cfg_load_data, want} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      check("reset value", rd, rv[i]);
    end
    apb(1'b0, 8'h1c, 32'h0);
    check("unmapped data", rd, 32'h0);
    check("unmapped error", 32'(er), 32'h1);
    apb(1'b1, hpc_pkg::OFS_CTL, 32'h057);
    want[hpc_pkg::IN_PRS] <= 1'b1;
    repeat (10) @(posedge pclk);
    apb(1'b0, hpc_pkg::OFS_STS, 32'h0);
    check("idle presence", rd & 32'h8, 32'h0);
    check("idle power", 32'(pwr), 32'h0);
    want[hpc_pkg::IN_PRS] <= 1'b0;
    apb(1'b1, hpc_pkg::OFS_STS, 32'h1f);
    cfg_load_en   <= 1'b1;
    cfg_load_addr <= hpc_pkg::OFS_CAP;
    cfg_load_data <= 32'h7;
    @(posedge pclk);
    cfg_load_en <= 1'b0;
    repeat (6) @(posedge pclk);
    apb(1'b0, hpc_pkg::OFS_STS, 32'h0);
    check("load completion", rd & 32'h10, 32'h0);
    check("power on", 32'(pwr), 32'h1);
    $display("register tests done");
    apb(1'b1, hpc_pkg::OFS_WTMR, 32'h1);
    ev_case(32'h037, 0, 0, 0, hpc_pkg::IN_PRS, 40, 0, 0, 1);
    ev_case(32'h03e, 0, 0, 0, hpc_pkg::IN_BTN, 40, 0, 0, 1);
    ev_case(32'h03b, 0, 0, 0, hpc_pkg::IN_LAT, 40, 0, 0, 1);
    ev_case(32'h02f, 0, 0, 0, 5, 40, 0, 0, 1);
    ev_case(32'h017, 0, 0, 0, hpc_pkg::IN_PRS, 40, 0, 0, 0);
    ev_case(32'h03f, 3, 0, 0, hpc_pkg::IN_PRS, 40, 0, 0, 0);
    ev_case(32'h02f, 3, 0, 0, 5, 40, 0, 0, 1);
    ev_case(32'h017, 3, 0, 0, hpc_pkg::IN_PRS, 250, 3, 0, 0);
    ev_case(32'h037, 3, 0, 0, hpc_pkg::IN_PRS, 40, 1, 0, 1);
    ev_case(32'h017, 3, 1, 0, hpc_pkg::IN_PRS, 40, 0, 0, 0);
    ev_case(32'h017, 0, 0, 1, hpc_pkg::IN_PRS, 40, 1, 0, 0);
    apb(1'b1, hpc_pkg::OFS_IRQ, 32'h1);
    ev_case(32'h037, 0, 0, 0, hpc_pkg::IN_PRS, 40, 0, 1, 0);
    apb(1'b1, hpc_pkg::OFS_IRQ, 32'h2);
    ev_case(32'h037, 0, 0, 0, hpc_pkg::IN_PRS, 40, 0, 0, 0);
    apb(1'b1, hpc_pkg::OFS_IRQ, 32'h0);
    ev_case(32'h03d, 0, 0, 0, hpc_pkg::IN_PF, 40, 0, 0, 1);
    want[hpc_pkg::IN_PF] <= 1'b0;
    $display("event tests done");
    apb(1'b0, hpc_pkg::OFS_STS, 32'h0);
    check("lock flag off", rd & 32'h80, 32'h0);
    apb(1'b1, hpc_pkg::OFS_CFG, 32'h800);
    apb(1'b0, hpc_pkg::OFS_STS, 32'h0);
    check("latch as lock", rd & 32'ha0, 32'h80);
    apb(1'b1, hpc_pkg::OFS_CFG, 32'h1000);
    apb(1'b1, hpc_pkg::OFS_CTL, 32'h057);
    repeat (8) @(posedge pclk);
    check("latch open power", 32'(pwr), 32'h0);
    want[hpc_pkg::IN_LAT] <= 1'b0;
    repeat (8) @(posedge pclk);
    check("latch shut power", 32'(pwr), 32'h1);
    apb(1'b1, hpc_pkg::OFS_CFG, 32'h1080);
    repeat (4) @(posedge pclk);
    check("power inverted", 32'(pwr), 32'h0);
    apb(1'b1, hpc_pkg::OFS_CFG, 32'h0);
    apb(1'b1, hpc_pkg::OFS_CTL, 32'h217);
    n = 0;
    for (int i = 0; i < ILK + 20; i++) begin
      @(posedge pclk);
      if (ilk === 1'b1) n++;
    end
    check("lock pulse", 32'(n), 32'(ILK));
    apb(1'b1, hpc_pkg::OFS_CFG, 32'h400);
    apb(1'b1, hpc_pkg::OFS_CTL, 32'h217);
    repeat (4) @(posedge pclk);
    check("toggle on", 32'(ilk), 32'h1);
    apb(1'b1, hpc_pkg::OFS_CTL, 32'h217);
    repeat (4) @(posedge pclk);
    check("toggle off", 32'(ilk), 32'h0);
    apb(1'b1, hpc_pkg::OFS_CTL, 32'h417);
    repeat (4) @(posedge pclk);
    check("slot reset", 32'(srst), 32'h1);
    apb(1'b1, hpc_pkg::OFS_CTL, 32'h197);
    repeat (4) @(posedge pclk);
    check("attention led", 32'(attn), 32'h1);
    check("power led", 32'(pled), 32'h1);
    $display("slot output tests done");
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    tally_and_finish();
  end
endmodule
